/* File: src/quad_wiper_position_control.sv */
// serial slave, wiper position registers and stored settings of a quad potentiometer
//
// Overview of operation
// R1 - slave samples serial input on clock rise
// R2 - host holds select low, pause/protect high
// R3 - serial output driven only for read data
// R4 - 63 segments, 64 taps per potentiometer
// R5 - exactly one tap switch on per potentiometer
// R6 - 6-bit wiper value decoded one-hot to taps
// R7 - four wiper position registers, one per pot
// R8 - write-wiper command loads wiper serially
// R9 - single/global copy loads wiper from setting
// R10 - step command moves wiper one tap per pulse
// R11 - power-up loads wiper from setting register zero
// R12 - wipers volatile; only setting zero restores
// R13 - four 6-bit stored settings per pot, host access
// R14 - copy both ways between wiper and settings
// R15 - setting change is nonvolatile, within 10ms
// R16 - commit starts on select rise after full sequence
// R17 - write pending flag set during commit, readable
// R18 - read data shifted out on clock fall
// R19 - pause input freezes sequence while clock low
// R20 - ignore activity until select falls after power-up
// R21 - write protect low blocks nonvolatile writes
// R22 - incomplete sequence discarded without any effect
// R23 - step saturates at top and bottom taps
`timescale 1ns/1ps

module quad_wiper_position_control #(
  parameter int         NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYCLES,
  parameter logic [3:0] DEVICE_TYPE_ID  = pot_pkg::DEVICE_TYPE_ID_DEFAULT
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // serial link pins
  input  wire logic                cs_n,
  input  wire logic                sck,
  input  wire logic                si,
  input  wire logic                hold_n,
  input  wire logic                wp_n,
  input  wire logic [1:0]          board_select_inputs,
  output logic                     so_data,
  output logic                     so_oe_n,
  // tap switches and status
  output logic [pot_pkg::POT_COUNT-1:0][pot_pkg::TAP_COUNT-1:0] tap_enable,
  output logic                     write_pending_flag
);
  import pot_pkg::*;

  localparam int CNT_W = $clog2(NV_WRITE_CYCLES + 1);

  // ==========================================================================
  // pin synchronisers
  localparam int PIN_W = 7;
  logic [PIN_W-1:0] pins_meta_reg;
  logic [PIN_W-1:0] pins_sync_reg;
  logic             cs_prev_reg;
  logic             sck_prev_reg;
  logic             cs_s;
  logic             sck_s;
  logic             si_s;
  logic             hold_s;
  logic             wp_s;
  logic [1:0]       bsel_s;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
    end else begin
      pins_meta_reg <= {cs_n, sck, si, hold_n, wp_n, board_select_inputs};
      pins_sync_reg <= pins_meta_reg;
    end
  end

  assign {cs_s, sck_s, si_s, hold_s, wp_s, bsel_s} = pins_sync_reg;

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      cs_prev_reg  <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg  <= cs_s;
      sck_prev_reg <= sck_s;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;

  // a reset cs history of zero means a select already low is never taken as a fall
  assign cs_fall  = cs_prev_reg & ~cs_s;                    // see R20
  assign cs_rise  = ~cs_prev_reg & cs_s;
  // pause only starts and ends with the clock low, so gating loses no edge
  assign sck_rise = sck_s & ~sck_prev_reg & hold_s & ~cs_s;  // see R1, R19
  assign sck_fall = ~sck_s & sck_prev_reg & hold_s & ~cs_s;  // see R18, R19

  // ==========================================================================
  // storage
  logic [5:0]  wiper_reg [POT_COUNT];
  // nonvolatile cells are not touched by reset; erased cells start at zero
  logic [5:0]  setting_mem [POT_COUNT][SETTING_COUNT] = '{default: 6'h00};
  logic        boot_reg;
  logic        busy_reg;

  function automatic logic [TAP_COUNT-1:0] tap_onehot(input logic [5:0] pos);
    logic [TAP_COUNT-1:0] v;
    v = '0;
    v[pos] = 1'b1;
    return v;
  endfunction

  function automatic logic [7:0] pad_byte(input logic [5:0] val);
    return {2'h0, val};
  endfunction

  // ==========================================================================
  // serial sequence engine
  phase_e     phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  instr_s     instr_reg;
  logic [7:0] tx_reg;
  logic       wr_wiper_reg;
  logic       load_wiper_reg;
  wiper_evt_s evt_reg;
  nv_req_s    nv_req_reg;
  logic [7:0] rx_byte;
  instr_s     rx_instr;
  logic       byte_done;

  assign rx_byte   = {shift_reg, si_s};
  assign rx_instr  = instr_s'(rx_byte);
  assign byte_done = sck_rise && (bit_cnt_reg == 3'h7);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      phase_reg      <= PH_IDLE;
      bit_cnt_reg    <= 3'h0;
      shift_reg      <= 7'h00;
      instr_reg      <= '0;
      tx_reg         <= 8'h00;
      wr_wiper_reg   <= 1'b0;
      load_wiper_reg <= 1'b0;
      evt_reg        <= '0;
      nv_req_reg     <= '0;
    end else begin
      wr_wiper_reg   <= 1'b0;
      load_wiper_reg <= 1'b0;
      if (cs_s) begin
        // anything short of a complete sequence dies here
        phase_reg   <= PH_IDLE;                              // see R22
        bit_cnt_reg <= 3'h0;
        nv_req_reg  <= '0;
      end else if (phase_reg == PH_IDLE) begin
        if (cs_fall) begin
          phase_reg <= PH_ID;                                // see R20
        end
      end else if (sck_rise) begin
        shift_reg   <= rx_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done) begin
          unique case (phase_reg)
            PH_ID: begin
              if (rx_byte[7:ID_TYPE_LSB] == DEVICE_TYPE_ID &&
                  rx_byte[ID_TYPE_LSB-1:ID_ZERO_LSB] == ID_ZERO_VALUE &&
                  rx_byte[ID_ZERO_LSB-1:ID_ADDR_LSB] == bsel_s) begin
                phase_reg <= PH_INSTR;
              end else begin
                phase_reg <= PH_DONE;
              end
            end
            PH_INSTR: begin
              instr_reg           <= rx_instr;
              evt_reg.reg_sel     <= rx_instr.reg_sel;
              evt_reg.pot_sel     <= rx_instr.pot_sel;
              evt_reg.global_all  <= 1'b0;
              phase_reg           <= PH_DONE;
              case (rx_instr.op)
                OP_READ_WIPER: begin
                  tx_reg    <= pad_byte(wiper_reg[rx_instr.pot_sel]);
                  phase_reg <= PH_READ;
                end
                OP_READ_SETTING: begin
                  tx_reg    <= pad_byte(setting_mem[rx_instr.pot_sel][rx_instr.reg_sel]);
                  phase_reg <= PH_READ;                      // see R13
                end
                OP_READ_STATUS: begin
                  tx_reg                 <= 8'h00;
                  tx_reg[STATUS_WIP_BIT] <= busy_reg;         // see R17
                  phase_reg              <= PH_READ;
                end
                OP_WRITE_WIPER, OP_WRITE_SETTING: begin
                  phase_reg <= PH_WRITE;
                end
                OP_COPY_SETTING_TO_WIPER: begin
                  load_wiper_reg <= 1'b1;                    // see R9, R14
                end
                OP_GLOBAL_SETTING_TO_WIPER: begin
                  load_wiper_reg     <= 1'b1;                // see R9
                  evt_reg.global_all <= 1'b1;
                end
                OP_COPY_WIPER_TO_SETTING, OP_GLOBAL_WIPER_TO_SETTING: begin
                  nv_req_reg <= '{valid: 1'b1, from_wiper: 1'b1,
                                  global_all: (rx_instr.op == OP_GLOBAL_WIPER_TO_SETTING),
                                  reg_sel: rx_instr.reg_sel,
                                  pot_sel: rx_instr.pot_sel,
                                  value: 6'h00};             // see R14
                end
                OP_STEP: begin
                  phase_reg <= PH_STEP;
                end
                default: begin
                  phase_reg <= PH_DONE;
                end
              endcase
            end
            PH_WRITE: begin
              phase_reg     <= PH_DONE;
              evt_reg.value <= rx_byte[5:0];
              if (instr_reg.op == OP_WRITE_WIPER) begin
                wr_wiper_reg <= 1'b1;                        // see R8
              end else begin
                nv_req_reg <= '{valid: 1'b1, from_wiper: 1'b0, global_all: 1'b0,
                                reg_sel: instr_reg.reg_sel,
                                pot_sel: instr_reg.pot_sel,
                                value: rx_byte[5:0]};        // see R13
              end
            end
            PH_READ: begin
              phase_reg <= PH_DONE;
            end
            default: begin
              phase_reg <= phase_reg;
            end
          endcase
        end
      end else if (sck_fall && phase_reg == PH_READ) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
    end
  end

  // ==========================================================================
  // serial output
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      so_data <= 1'b0;
    end else if (sck_fall && phase_reg == PH_READ) begin
      so_data <= tx_reg[7];                                  // see R18
    end
  end

  // released outside a read so input and output may share one wire
  assign so_oe_n = (phase_reg != PH_READ);                   // see R3

  // ==========================================================================
  // wiper position registers
  logic step_pulse;
  assign step_pulse = sck_rise && (phase_reg == PH_STEP);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      boot_reg <= 1'b1;
      for (int p = 0; p < POT_COUNT; p++) begin
        wiper_reg[p] <= WIPER_RESET_VALUE;
      end
    end else begin
      boot_reg <= 1'b0;
      if (boot_reg) begin
        for (int p = 0; p < POT_COUNT; p++) begin
          wiper_reg[p] <= setting_mem[p][0];                 // see R11, R12
        end
      end else if (wr_wiper_reg) begin
        wiper_reg[evt_reg.pot_sel] <= evt_reg.value;         // see R7, R8
      end else if (load_wiper_reg) begin
        for (int p = 0; p < POT_COUNT; p++) begin
          if (evt_reg.global_all || evt_reg.pot_sel == 2'(p)) begin
            wiper_reg[p] <= setting_mem[p][evt_reg.reg_sel]; // see R9
          end
        end
      end else if (step_pulse) begin
        if (si_s && wiper_reg[instr_reg.pot_sel] != TAP_TOP) begin
          wiper_reg[instr_reg.pot_sel] <= wiper_reg[instr_reg.pot_sel] + 6'h01; // see R10, R23
        end else if (!si_s && wiper_reg[instr_reg.pot_sel] != TAP_BOTTOM) begin
          wiper_reg[instr_reg.pot_sel] <= wiper_reg[instr_reg.pot_sel] - 6'h01; // see R10, R23
        end
      end
    end
  end

  // ==========================================================================
  // tap switch decode
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      tap_enable <= '{default: {{(TAP_COUNT-1){1'b0}}, 1'b1}};
    end else begin
      for (int p = 0; p < POT_COUNT; p++) begin
        tap_enable[p] <= tap_onehot(wiper_reg[p]);           // see R4, R5, R6
      end
    end
  end

  // ==========================================================================
  // nonvolatile commit
  logic [CNT_W-1:0] nv_cnt_reg;
  logic [5:0]       nv_val_reg  [POT_COUNT];
  logic [POT_COUNT-1:0] nv_mask_reg;
  logic [1:0]       nv_sel_reg;
  logic             nv_start;

  // a busy array or a protected device drops the request silently
  assign nv_start = cs_rise && nv_req_reg.valid && wp_s && !busy_reg; // see R16, R21

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      busy_reg    <= 1'b0;
      nv_cnt_reg  <= '0;
      nv_mask_reg <= '0;
      nv_sel_reg  <= 2'h0;
      for (int p = 0; p < POT_COUNT; p++) begin
        nv_val_reg[p] <= 6'h00;
      end
    end else if (nv_start) begin
      busy_reg   <= 1'b1;                                    // see R17
      nv_cnt_reg <= CNT_W'(NV_WRITE_CYCLES - 1);             // see R15
      nv_sel_reg <= nv_req_reg.reg_sel;
      for (int p = 0; p < POT_COUNT; p++) begin
        nv_mask_reg[p] <= nv_req_reg.global_all || nv_req_reg.pot_sel == 2'(p);
        nv_val_reg[p]  <= nv_req_reg.from_wiper ? wiper_reg[p] : nv_req_reg.value;
      end
    end else if (busy_reg) begin
      if (nv_cnt_reg == '0) begin
        busy_reg <= 1'b0;
      end else begin
        nv_cnt_reg <= nv_cnt_reg - CNT_W'(1);
      end
    end
  end

  // cells change only at the end of the commit time
  always_ff @(posedge mclk) begin
    if (nrst && busy_reg && nv_cnt_reg == '0) begin
      for (int p = 0; p < POT_COUNT; p++) begin
        if (nv_mask_reg[p]) begin
          setting_mem[p][nv_sel_reg] <= nv_val_reg[p];       // see R14, R15
        end
      end
    end
  end

  assign write_pending_flag = busy_reg;                      // see R17

endmodule

/* File: common/pot_pkg.sv */
// constants, encodings and carrier types of the quad wiper position control
package pot_pkg;

  // ==========================================================================
  // array geometry
  localparam int POT_COUNT     = 4;
  localparam int SETTING_COUNT = 4;
  localparam int TAP_BITS      = 6;
  localparam int SEGMENT_COUNT = 63;
  localparam int TAP_COUNT     = SEGMENT_COUNT + 1;
  localparam logic [5:0] TAP_TOP    = 6'h3f;
  localparam logic [5:0] TAP_BOTTOM = 6'h00;
  localparam logic [5:0] WIPER_RESET_VALUE = 6'h00;

  // ==========================================================================
  // timing
  localparam int CLK_HZ            = 40_000_000;
  localparam int NV_WRITE_TIME_MS  = 10;
  // longest time: rounds down
  localparam int NV_WRITE_CYCLES   = NV_WRITE_TIME_MS * (CLK_HZ / 1000);

  // ==========================================================================
  // identification byte: type[7:4], zero[3:2], board select[1:0]
  localparam logic [3:0] DEVICE_TYPE_ID_DEFAULT = 4'ha; // arbitrary value
  localparam int ID_TYPE_LSB = 4;
  localparam int ID_ZERO_LSB = 2;
  localparam int ID_ADDR_LSB = 0;
  localparam logic [1:0] ID_ZERO_VALUE = 2'h0;

  // ==========================================================================
  // instruction codes (upper nibble of the instruction byte)
  localparam logic [3:0] OP_READ_WIPER           = 4'h9;
  localparam logic [3:0] OP_WRITE_WIPER          = 4'ha;
  localparam logic [3:0] OP_READ_SETTING         = 4'hb;
  localparam logic [3:0] OP_WRITE_SETTING        = 4'hc;
  localparam logic [3:0] OP_COPY_SETTING_TO_WIPER = 4'hd;
  localparam logic [3:0] OP_COPY_WIPER_TO_SETTING = 4'he;
  localparam logic [3:0] OP_GLOBAL_SETTING_TO_WIPER = 4'h1;
  localparam logic [3:0] OP_GLOBAL_WIPER_TO_SETTING = 4'h8;
  localparam logic [3:0] OP_STEP                 = 4'h2;
  localparam logic [3:0] OP_READ_STATUS          = 4'h3;

  // status byte
  localparam int STATUS_WIP_BIT = 0;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [3:0] op;
    logic [1:0] reg_sel;
    logic [1:0] pot_sel;
  } instr_s;

  typedef struct packed {
    logic       global_all;
    logic [1:0] reg_sel;
    logic [1:0] pot_sel;
    logic [5:0] value;
  } wiper_evt_s;

  typedef struct packed {
    logic       valid;
    logic       from_wiper;
    logic       global_all;
    logic [1:0] reg_sel;
    logic [1:0] pot_sel;
    logic [5:0] value;
  } nv_req_s;

  typedef enum {
    PH_IDLE,
    PH_ID,
    PH_INSTR,
    PH_WRITE,
    PH_READ,
    PH_STEP,
    PH_DONE
  } phase_e;

endpackage

/* File: verif/quad_wiper_position_control_asserts.sv */
// port checker of the quad wiper position control
`timescale 1ns/1ps

module quad_wiper_position_control_asserts #(
  parameter int NV_WRITE_CYCLES = 50
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // link pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_data,
  input wire logic so_oe_n,
  // taps and status
  input wire logic [pot_pkg::POT_COUNT-1:0][pot_pkg::TAP_COUNT-1:0] tap_enable,
  input wire logic write_pending_flag
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // ======
  // helpers
  int         busy_cnt;
  logic [2:0] up_cnt;
  always_ff @(posedge mclk) begin
    if (!nrst || !write_pending_flag) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  // power-up reload lands in the first cycles, so idle checks wait
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      up_cnt <= 3'h0;
    end else if (!up_cnt[2]) begin
      up_cnt <= up_cnt + 3'h1;
    end
  end

  // ======
  // assertions
  tap_one_hot_a: assert property ($onehot(tap_enable[0]) && $onehot(tap_enable[1])
    && $onehot(tap_enable[2]) && $onehot(tap_enable[3])) else $error("tap not one-hot");
  idle_output_a: assert property (cs_n [*4] |-> so_oe_n) else $error("output on");
  out_on_fall_a: assert property (!so_oe_n && $changed(so_data) |-> !sck)
    else $error("read bit moved with clock high");
  commit_start_a: assert property ($rose(write_pending_flag) |-> cs_n && $past(cs_n, 2))
    else $error("commit began while selected");
  commit_length_a: assert property ($fell(write_pending_flag)
    |-> busy_cnt == NV_WRITE_CYCLES) else $error("commit length wrong");
  protect_block_a: assert property ($rose(cs_n) && !wp_n && !$past(wp_n, 3)
    |-> ##1 (!$rose(write_pending_flag)) [*6]) else $error("protected commit ran");
  pause_freeze_a: assert property ((!hold_n) [*4]
    |-> $stable(tap_enable) && $stable(so_data)) else $error("link moved in pause");
  idle_quiet_a: assert property ((cs_n && up_cnt[2]) [*4] |-> $stable(tap_enable))
    else $error("wiper moved while idle");

  commit_c: cover property ($rose(write_pending_flag));
  read_c: cover property ($fell(so_oe_n));
  pause_c: cover property ((!hold_n) [*4]);
endmodule

bind quad_wiper_position_control quad_wiper_position_control_asserts #(
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) i_asserts (.mclk, .nrst, .cs_n, .sck, .hold_n, .wp_n, .so_data, .so_oe_n,
  .tap_enable, .write_pending_flag);

/* File: verif/spi_host_model.sv */
// serial host model driving select, clock, data, pause and protect pins
`timescale 1ns/1ps

module spi_host_model (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n,
  output logic      wp_n,
  input  wire logic so_data,
  input  wire logic so_oe_n
);
  logic [7:0] rd_byte;
  logic       saw;
  event       rd_done;

  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    wp_n = 1'b1;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // n bits msb first; pause holds the link before bit 17
  task automatic frame(input logic [31:0] bits, input int n, input logic pause, input logic prot);
    saw = 1'b0;
    wp_n = prot;
    cs_n = 1'b0;
    wait_n(4);
    for (int i = 0; i < n; i++) begin
      if (pause && i == 17) begin
        // clock must already be low when the pause starts
        wait_n(4);
        hold_n = 1'b0;
        wait_n(4);
        repeat (2) begin
          sck = 1'b1;
          wait_n(4);
          sck = 1'b0;
          wait_n(4);
        end
        hold_n = 1'b1;
        wait_n(4);
      end
      si = bits[31-i];
      wait_n(4);
      sck = 1'b1;
      if (i >= 16) begin
        saw = saw | !so_oe_n;
        rd_byte = {rd_byte[6:0], so_oe_n ? 1'bz : so_data};
      end
      wait_n(4);
      sck = 1'b0;
    end
    wait_n(4);
    // released line shows the inverse, never a held value
    si = ~si;
    cs_n = 1'b1;
    wait_n(8);
    wp_n = 1'b1;
    if (saw) begin
      -> rd_done;
    end
  endtask
endmodule

/* File: verif/quad_wiper_position_control_test.sv */
// self-checking bench of the quad wiper position control
`timescale 1ns/1ps

module quad_wiper_position_control_test;
  import pot_pkg::*;
  typedef struct packed {
    logic       tap;
    logic [1:0] pot;
    logic [7:0] val;
  } note_s;
  localparam int NV = 300;
  localparam logic [5:0] FROM [3] = '{6'h05, 6'h01, 6'h3e};
  localparam logic [5:0] TO [3] = '{6'h02, 6'h00, 6'h3f};
  localparam logic UP [3] = '{1'b0, 1'b0, 1'b1};
  localparam logic HOLD [3] = '{1'b1, 1'b0, 1'b0};
  logic mclk, nrst, cs_n, sck, si, hold_n, wp_n, so_data, so_oe_n, write_pending_flag;
  logic [1:0] bsel;
  logic [POT_COUNT-1:0][TAP_COUNT-1:0] tap_enable;
  logic [5:0] st [4][4];
  logic [5:0] wpos [4];
  note_s q [$];
  int fails, checks;

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;

  quad_wiper_position_control #(.NV_WRITE_CYCLES(NV)) i_dut (.mclk, .nrst, .cs_n, .sck,
    .si, .hold_n, .wp_n, .board_select_inputs(bsel), .so_data, .so_oe_n, .tap_enable,
    .write_pending_flag);
  spi_host_model i_host (.mclk, .cs_n, .sck, .si, .hold_n, .wp_n, .so_data, .so_oe_n);

  // ======
  // checking
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(i_host.rd_done) begin
    note_s n;
    n = q.size() > 0 ? q.pop_front() : '1;
    check("read byte", 64'(i_host.rd_byte), 64'(n.val));
    if (n.tap) begin
      check("tap switch", tap_enable[n.pot], 64'h1 << n.val[5:0]);
    end
  end

  // ======
  // stimulus
  function automatic logic [15:0] hdr(logic [3:0] op, logic [1:0] r, logic [1:0] p);
    return {DEVICE_TYPE_ID_DEFAULT, 2'h0, bsel, op, r, p};
  endfunction

  task automatic cmd(logic [3:0] op, logic [1:0] r, logic [1:0] p, logic [7:0] d,
                     int n = 24, logic prot = 1'b1);
    i_host.frame({hdr(op, r, p), d, 8'h0}, n, 1'b0, prot);
  endtask

  task automatic rd(logic [3:0] op, logic [1:0] r, logic [1:0] p, logic [5:0] v, logic t);
    q.push_back({t, p, 2'h0, v});
    cmd(op, r, p, 8'h0);
  endtask

  task automatic settle();
    for (int k = 0; write_pending_flag !== 1'b0; k++) begin
      if (k > 2 * NV) begin
        check("commit end", 1, 0);
        results();
      end
      @(negedge mclk);
    end
  endtask

  task automatic power_up();
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
  endtask

  initial begin
    void'($urandom(78874));
    bsel = 2'($urandom());
    power_up();
    foreach (st[p, r]) begin
      st[p][r] = 6'($urandom());
      cmd(OP_WRITE_SETTING, 2'(r), 2'(p), {2'h3, st[p][r]});
      settle();
    end
    foreach (st[p, r]) rd(OP_READ_SETTING, 2'(r), 2'(p), st[p][r], 1'b0);
    $display("test stored settings done");
    power_up();
    for (int p = 0; p < 4; p++) rd(OP_READ_WIPER, 2'h0, 2'(p), st[p][0], 1'b1);
    $display("test power-up reload done");
    foreach (wpos[p]) begin
      wpos[p] = 6'($urandom());
      cmd(OP_WRITE_WIPER, 2'h0, 2'(p), {2'h0, wpos[p]});
    end
    foreach (wpos[p]) rd(OP_READ_WIPER, 2'h0, 2'(p), wpos[p], 1'b1);
    $display("test wiper write done");
    for (int i = 0; i < 3; i++) begin
      cmd(OP_WRITE_WIPER, 2'h0, 2'h2, {2'h0, FROM[i]});
      i_host.frame({hdr(OP_STEP, 2'h0, 2'h2), {8{UP[i]}}, 8'h0}, 19, HOLD[i], 1'b1);
      rd(OP_READ_WIPER, 2'h0, 2'h2, TO[i], 1'b1);
    end
    wpos[2] = 6'h3f;
    $display("test step done");
    cmd(OP_COPY_SETTING_TO_WIPER, 2'h2, 2'h1, 8'h0, 16);
    rd(OP_READ_WIPER, 2'h0, 2'h1, st[1][2], 1'b1);
    cmd(OP_GLOBAL_SETTING_TO_WIPER, 2'h3, 2'h0, 8'h0, 16);
    foreach (wpos[p]) begin
      wpos[p] = st[p][3];
      rd(OP_READ_WIPER, 2'h0, 2'(p), wpos[p], 1'b1);
    end
    $display("test copy to wiper done");
    cmd(OP_COPY_WIPER_TO_SETTING, 2'h1, 2'h3, 8'h0, 16);
    settle();
    st[3][1] = wpos[3];
    cmd(OP_GLOBAL_WIPER_TO_SETTING, 2'h2, 2'h0, 8'h0, 16);
    settle();
    rd(OP_READ_SETTING, 2'h1, 2'h3, st[3][1], 1'b0);
    foreach (wpos[p]) rd(OP_READ_SETTING, 2'h2, 2'(p), wpos[p], 1'b0);
    $display("test copy to setting done");
    st[0][0] = ~st[0][0];
    cmd(OP_WRITE_SETTING, 2'h0, 2'h0, {2'h0, st[0][0]});
    rd(OP_READ_STATUS, 2'h0, 2'h0, 6'h01, 1'b0);
    settle();
    rd(OP_READ_STATUS, 2'h0, 2'h0, 6'h00, 1'b0);
    rd(OP_READ_SETTING, 2'h0, 2'h0, st[0][0], 1'b0);
    $display("test write pending done");
    cmd(OP_WRITE_SETTING, 2'h0, 2'h1, {2'h0, ~st[1][0]}, 24, 1'b0);
    rd(OP_READ_STATUS, 2'h0, 2'h0, 6'h00, 1'b0);
    rd(OP_READ_SETTING, 2'h0, 2'h1, st[1][0], 1'b0);
    cmd(OP_WRITE_SETTING, 2'h1, 2'h1, {2'h0, ~st[1][1]}, 20);
    rd(OP_READ_STATUS, 2'h0, 2'h0, 6'h00, 1'b0);
    rd(OP_READ_SETTING, 2'h1, 2'h1, st[1][1], 1'b0);
    // a foreign board address must leave the wiper alone
    i_host.frame({hdr(OP_WRITE_WIPER, 2'h0, 2'h0) ^ 16'h0100, 2'h0, ~wpos[0], 8'h0}, 24,
                 1'b0, 1'b1);
    rd(OP_READ_WIPER, 2'h0, 2'h0, wpos[0], 1'b1);
    $display("test refused writes done");
    // let the checking process take the last note first
    @(negedge mclk);
    check("unread notes", q.size(), 0);
    results();
  end
endmodule
